// File: pkg/pvf_pkg.sv
`default_nettype none
// ****************************************************************
// paging vector packet formatter constants
// ****************************************************************
package pvf_pkg;

  // register offsets, byte addresses on the register port
  localparam int          REG_AW        = 4;
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam logic [3:0]  REG_MASK      = 4'h8;
  localparam logic [3:0]  REG_STATE     = 4'hc;

  // control register fields and reset value
  localparam int          CTRL_ENABLE   = 0;
  localparam int          CTRL_AF_EXIT  = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h1;

  // status and mask fields, one per event
  localparam int          ST_SENT       = 0;
  localparam int          ST_OVERRUN    = 1;
  localparam int          ST_NOVEC      = 2;
  localparam int          ST_MSGDROP    = 3;
  localparam int          ST_W          = 4;
  localparam logic [3:0]  MASK_RESET    = 4'h0;

  // state register fields
  localparam int          SR_ALL_FRAME  = 0;
  localparam int          SR_PKT_READY  = 1;
  localparam int          SR_ADDR_PEND  = 2;

  // vector type codes
  localparam logic [2:0]  VT_SECURE     = 3'h0;
  localparam logic [2:0]  VT_SHORT_INS  = 3'h1;
  localparam logic [2:0]  VT_SHORT_MSG  = 3'h2;
  localparam logic [2:0]  VT_STD_NUM    = 3'h3;
  localparam logic [2:0]  VT_SPEC_NUM   = 3'h4;
  localparam logic [2:0]  VT_ALPHA      = 3'h5;
  localparam logic [2:0]  VT_HEX        = 3'h6;
  localparam logic [2:0]  VT_NUMBERED   = 3'h7;

  // value limits
  localparam logic [6:0]  WP_VEC_MIN    = 7'h02;
  localparam logic [6:0]  WP_MSG_MIN    = 7'h03;
  localparam logic [6:0]  WP_MAX        = 7'h57;
  localparam logic [6:0]  CNT_MIN       = 7'h01;
  localparam logic [6:0]  CNT_MAX       = 7'h55;
  localparam logic [2:0]  ERR_LIMIT     = 3'h2;

  // packet layout: byte 3 is bits 31..24
  localparam int          PKT_BITS      = 32;
  localparam logic [5:0]  PKT_BITS_C    = 6'h20;
  localparam int          PKT_ERR_BIT   = 23;
  localparam int          PKT_PH_HI     = 22;
  localparam int          PKT_PH_LO     = 21;
  localparam int          PKT_VT_HI     = 18;
  localparam int          PKT_VT_LO     = 16;

  // serial link states
  typedef enum logic [1:0] {
    LK_IDLE  = 2'b00,
    LK_SHIFT = 2'b01
  } pvf_link_t;

endpackage
`default_nettype wire

// File: rtl/pvf_formatter.sv
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - byte 3 bit 7 is zero, bits 6..0 carry the vector word position.
// - error flag byte 2 bit 7 on over two bit errors, check fail, invalid value.
// - phase a..d coded 0..3 in byte 2 bits 6..5.
// - numeric type codes 011 standard, 100 special format, 111 numbered.
// - numeric packet carries four leading check bits in byte 1 bits 5..2.
// - numeric three-bit length over byte 1 bits 1..0 and byte 0 bit 7.
// - numeric message start position in byte 0 bits 6..0.
// - other type codes 000 secure, 101 alphanumeric, 110 hex/binary.
// - seven-bit word count over byte 1 bits 5..0 and byte 0 bit 7.
// - message start position in byte 0 bits 6..0, second word if long.
// - long address first message packet comes from position after vector word.
// - every non tone-only address packet is followed by a vector packet; no address packet is sent, a missing or misplaced vector sets status.
// - no message packets are sent for a vector with its error flag set.
// - hex, alpha, secure or short instruction vector enters all-frame mode.
module pvf_formatter
  import pvf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              addr_valid,
  input  wire logic              addr_tone_only,
  input  wire logic [6:0]        addr_position,
  input  wire logic              vec_valid,
  input  wire logic [2:0]        vec_type,
  input  wire logic [6:0]        vec_position,
  input  wire logic [1:0]        vec_phase,
  input  wire logic [2:0]        vec_bit_errors,
  input  wire logic              vec_check_fail,
  input  wire logic              vec_value_bad,
  input  wire logic              vec_long,
  input  wire logic [3:0]        vec_check_bits,
  input  wire logic [6:0]        vec_length,
  input  wire logic [6:0]        vec_start,
  input  wire logic              msg_valid,
  input  wire logic [6:0]        msg_position,
  input  wire logic [1:0]        msg_phase,
  input  wire logic              msg_error,
  input  wire logic [20:0]       msg_data,
  input  wire logic              link_sck,
  input  wire logic              link_sel_n,
  output logic                   link_miso,
  output logic                   pkt_ready,
  output logic                   all_frame,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   irq
);

  // ****************************************************************
  // register port
  // ****************************************************************
  logic [1:0]      ctrl_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] events;
  logic            all_frame_q;
  logic            addr_pend_q;
  logic            hold_valid_q;
  logic [31:0]     rdata_q;

  // control and mask writes; the exit bit is a command and never stored
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= MASK_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_q <= {1'b0, reg_wdata[CTRL_ENABLE]};
    end else if (reg_wr && reg_addr == REG_MASK) begin
      mask_q <= reg_wdata[ST_W-1:0];
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      status_q <= '0;
    end else if (reg_wr && reg_addr == REG_STATUS) begin
      status_q <= (status_q & ~reg_wdata[ST_W-1:0]) | events;
    end else begin
      status_q <= status_q | events;
    end
  end

  // read data one cycle after the strobe, zero elsewhere and when unmapped
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (!reg_rd) begin
      rdata_q <= '0;
    end else if (reg_addr == REG_CTRL) begin
      rdata_q <= {31'h0, ctrl_q[CTRL_ENABLE]};
    end else if (reg_addr == REG_STATUS) begin
      rdata_q <= {28'h0, status_q};
    end else if (reg_addr == REG_MASK) begin
      rdata_q <= {28'h0, mask_q};
    end else if (reg_addr == REG_STATE) begin
      rdata_q <= {29'h0, addr_pend_q, hold_valid_q, all_frame_q};
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = |(status_q & mask_q);

  // ****************************************************************
  // vector packet assembly
  // ****************************************************************
  logic        enable;
  logic        vec_numeric;
  logic        vec_long_msg;
  logic        vec_err;
  logic        vec_load_req;
  logic [7:0]  byte3;
  logic [7:0]  byte2;
  logic [7:0]  byte1;
  logic [7:0]  byte0;
  logic [31:0] vec_pkt;
  logic [31:0] msg_pkt;

  assign enable       = ctrl_q[CTRL_ENABLE];
  assign vec_numeric  = (vec_type == VT_STD_NUM) || (vec_type == VT_SPEC_NUM) ||
                        (vec_type == VT_NUMBERED);
  assign vec_long_msg = (vec_type == VT_SECURE) || (vec_type == VT_ALPHA) ||
                        (vec_type == VT_HEX);

  // range checks stand in for value validation of the vector word
  always_comb begin
    vec_err = (vec_bit_errors > ERR_LIMIT) || vec_check_fail || vec_value_bad;
    if (vec_position < WP_VEC_MIN || vec_position > WP_MAX) begin
      vec_err = 1'b1;
    end
    if (vec_start < WP_MSG_MIN || vec_start > WP_MAX) begin
      vec_err = 1'b1;
    end
    if (vec_long_msg && (vec_length < CNT_MIN || vec_length > CNT_MAX)) begin
      vec_err = 1'b1;
    end
  end

  // unused positions are driven low, though the host may not rely on it
  always_comb begin
    byte3 = {1'b0, vec_position};
    byte2 = {vec_err, vec_phase, 2'b00, vec_type};
    if (vec_numeric) begin
      byte1 = {2'b00, vec_check_bits, vec_length[2:1]};
      byte0 = {vec_length[0], vec_start};
    end else begin
      byte1 = {2'b00, vec_length[6:1]};
      byte0 = {vec_length[0], vec_start};
    end
    vec_pkt = {byte3, byte2, byte1, byte0};
  end

  assign msg_pkt      = {1'b0, msg_position, msg_error, msg_phase, msg_data};
  assign vec_load_req = enable && vec_valid && (vec_numeric || vec_long_msg);

  // ****************************************************************
  // address follow-up and all-frame mode
  // ****************************************************************
  logic [6:0] addr_pos_q;
  logic       vec_orphan;
  logic       addr_missed;

  // a vector must close each non tone-only address at the same position
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_pend_q <= 1'b0;
      addr_pos_q  <= '0;
    end else if (addr_valid && !addr_tone_only) begin
      addr_pend_q <= 1'b1;
      addr_pos_q  <= addr_position;
    end else if (vec_valid) begin
      addr_pend_q <= 1'b0;
    end
  end

  assign addr_missed = addr_valid && !addr_tone_only && addr_pend_q && !vec_valid;
  assign vec_orphan  = vec_valid && addr_pend_q && (vec_position != addr_pos_q);

  // entering all-frame mode wins over a same-cycle exit command
  always_ff @(posedge clk) begin
    if (reset) begin
      all_frame_q <= 1'b0;
    end else if (enable && vec_valid && (vec_long_msg || vec_type == VT_SHORT_INS)) begin
      all_frame_q <= 1'b1;
    end else if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_AF_EXIT]) begin
      all_frame_q <= 1'b0;
    end
  end

  assign all_frame = all_frame_q;

  // ****************************************************************
  // message window of the last vector
  // ****************************************************************
  logic       ctx_valid_q;
  logic       ctx_err_q;
  logic       ctx_long_q;
  logic [1:0] ctx_phase_q;
  logic [6:0] ctx_first_q;
  logic [6:0] ctx_start_q;
  logic [7:0] ctx_end_q;
  logic       ctx_rest_q;
  logic [7:0] vec_count;
  logic [7:0] vec_rest;
  logic       msg_first;
  logic       msg_in_win;
  logic       msg_load_req;

  // numeric length is coded one less than the word count
  assign vec_count = vec_numeric ? {5'h0, vec_length[2:0]} + 8'h01 : {1'b0, vec_length};
  assign vec_rest  = vec_long ? vec_count - 8'h01 : vec_count;

  // only one vector is tracked; a newer numeric or long-message vector closes the older window
  always_ff @(posedge clk) begin
    if (reset) begin
      ctx_valid_q <= 1'b0;
      ctx_err_q   <= 1'b0;
      ctx_long_q  <= 1'b0;
      ctx_phase_q <= '0;
      ctx_first_q <= '0;
      ctx_start_q <= '0;
      ctx_end_q   <= '0;
      ctx_rest_q  <= 1'b0;
    end else if (vec_load_req) begin
      ctx_valid_q <= 1'b1;
      ctx_err_q   <= vec_err;
      ctx_long_q  <= vec_long;
      ctx_phase_q <= vec_phase;
      ctx_first_q <= vec_position + 7'h01;
      ctx_start_q <= vec_start;
      ctx_end_q   <= {1'b0, vec_start} + vec_rest - 8'h01;
      ctx_rest_q  <= (vec_rest != 8'h00);
    end
  end

  assign msg_first  = ctx_long_q && (msg_position == ctx_first_q);
  assign msg_in_win = ctx_rest_q && (msg_position >= ctx_start_q) &&
                      ({1'b0, msg_position} <= ctx_end_q);
  assign msg_load_req = enable && msg_valid && ctx_valid_q && !ctx_err_q &&
                        (msg_phase == ctx_phase_q) && (msg_first || msg_in_win);

  // ****************************************************************
  // packet hold register
  // ****************************************************************
  logic [31:0] hold_q;
  logic        pkt_req;
  logic        pkt_load;
  logic        consume;
  logic        msg_drop;

  // a vector takes the slot before a message arriving in the same cycle
  assign pkt_req  = vec_load_req || msg_load_req;
  assign pkt_load = pkt_req && (!hold_valid_q || consume);
  assign msg_drop = enable && msg_valid && ctx_valid_q && ctx_err_q &&
                    (msg_phase == ctx_phase_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      hold_valid_q <= 1'b0;
      hold_q       <= '0;
    end else if (pkt_load) begin
      hold_valid_q <= 1'b1;
      hold_q       <= vec_load_req ? vec_pkt : msg_pkt;
    end else if (consume) begin
      hold_valid_q <= 1'b0;
    end
  end

  assign pkt_ready = hold_valid_q;

  // ****************************************************************
  // serial packet link
  // ****************************************************************
  logic [2:0]  sck_sync_q;
  logic [2:0]  sel_sync_q;
  logic        sck_rise;
  logic        sck_fall;
  logic        sel_start;
  logic        sel_end;
  pvf_link_t   link_q;
  logic [31:0] shift_q;
  logic [5:0]  bit_cnt_q;
  logic        loaded_q;

  // two flops per pin, the third stage only feeds edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      sck_sync_q <= '0;
      sel_sync_q <= 3'h7;
    end else begin
      sck_sync_q <= {sck_sync_q[1:0], link_sck};
      sel_sync_q <= {sel_sync_q[1:0], link_sel_n};
    end
  end

  assign sck_rise  = sck_sync_q[1] && !sck_sync_q[2];
  assign sck_fall  = !sck_sync_q[1] && sck_sync_q[2];
  assign sel_start = !sel_sync_q[1] && sel_sync_q[2];
  assign sel_end   = sel_sync_q[1] && !sel_sync_q[2];

  // a frame cut short keeps the packet, so the host can simply retry
  assign consume = (link_q == LK_SHIFT) && sel_end && loaded_q &&
                   (bit_cnt_q == PKT_BITS_C);

  // msb first: bit 31 presented at select, next bit after each falling edge
  always_ff @(posedge clk) begin
    if (reset) begin
      link_q    <= LK_IDLE;
      shift_q   <= '0;
      bit_cnt_q <= '0;
      loaded_q  <= 1'b0;
    end else begin
      case (link_q)
        LK_IDLE: begin
          if (sel_start) begin
            link_q    <= LK_SHIFT;
            shift_q   <= hold_valid_q ? hold_q : '0;
            loaded_q  <= hold_valid_q;
            bit_cnt_q <= '0;
          end
        end
        LK_SHIFT: begin
          if (sel_end) begin
            link_q <= LK_IDLE;
          end else begin
            if (sck_rise && bit_cnt_q != PKT_BITS_C) begin
              bit_cnt_q <= bit_cnt_q + 6'h01;
            end
            if (sck_fall) begin
              shift_q <= {shift_q[30:0], 1'b0};
            end
          end
        end
        default: begin
          link_q <= LK_IDLE;
        end
      endcase
    end
  end

  assign link_miso = shift_q[PKT_BITS-1];

  // event collection for the status register
  always_comb begin
    events              = '0;
    events[ST_SENT]     = consume;
    events[ST_OVERRUN]  = pkt_req && !pkt_load;
    events[ST_NOVEC]    = addr_missed || vec_orphan;
    events[ST_MSGDROP]  = msg_drop;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_msb_zero_pos: assert property (@(posedge clk) disable iff (reset)
    (pkt_load && vec_load_req) |=> (!hold_q[31] && hold_q[30:24] == $past(vec_position)))
    else $error("vector packet byte 3 wrong");

  a_error_flag: assert property (@(posedge clk) disable iff (reset)
    (pkt_load && vec_load_req && (vec_bit_errors > ERR_LIMIT || vec_check_fail || vec_value_bad))
    |=> hold_q[PKT_ERR_BIT])
    else $error("error flag missing");

  a_phase_code: assert property (@(posedge clk) disable iff (reset)
    (pkt_load && vec_load_req) |=> hold_q[PKT_PH_HI:PKT_PH_LO] == $past(vec_phase))
    else $error("phase code wrong");

  a_type_code: assert property (@(posedge clk) disable iff (reset)
    (pkt_load && vec_load_req) |=> hold_q[PKT_VT_HI:PKT_VT_LO] == $past(vec_type))
    else $error("vector type code wrong");

  a_num_fields: assert property (@(posedge clk) disable iff (reset)
    (pkt_load && vec_load_req && vec_numeric) |=>
    (hold_q[13:10] == $past(vec_check_bits) && {hold_q[9:8], hold_q[7]} == $past(vec_length[2:0])
     && hold_q[6:0] == $past(vec_start)))
    else $error("numeric fields wrong");

  a_word_count: assert property (@(posedge clk) disable iff (reset)
    (pkt_load && vec_load_req && vec_long_msg) |=>
    {hold_q[13:8], hold_q[7]} == $past(vec_length))
    else $error("word count wrong");

  a_err_no_msg: assert property (@(posedge clk) disable iff (reset)
    (ctx_valid_q && ctx_err_q && !vec_load_req) |-> !pkt_load)
    else $error("message sent for errored vector");

  a_long_first: assert property (@(posedge clk) disable iff (reset)
    (vec_load_req && vec_long) |=> (ctx_long_q && ctx_first_q == $past(vec_position) + 7'h01))
    else $error("first long message word position wrong");

  a_all_frame: assert property (@(posedge clk) disable iff (reset)
    (enable && vec_valid && (vec_type == VT_ALPHA || vec_type == VT_SHORT_INS))
    |=> all_frame ##1 (all_frame || $past(reg_wr)))
    else $error("all-frame mode not entered");

  a_full_packet: assert property (@(posedge clk) disable iff (reset)
    (link_q == LK_SHIFT && sel_end && bit_cnt_q != PKT_BITS_C && !pkt_load)
    |=> pkt_ready == $past(pkt_ready))
    else $error("cut frame lost the packet");

endmodule
`default_nettype wire

// File: dv/pvf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host controller reading packets over the serial link
// ****************************************************************
module pvf_host_model (
  input  wire logic link_miso,
  output logic      link_sck,
  output logic      link_sel_n
);
  // link clock idles low and stands still between frames
  initial begin
    link_sck   = 1'b0;
    link_sel_n = 1'b1;
  end

  // one frame, msb first, sampled on the rising link edge;
  // high phase kept short so the shifted bit has time to land
  task automatic read_packet(input int nbits, output logic [31:0] word);
    word       = 32'h0;
    link_sel_n = 1'b0;
    #200;
    for (int i = 0; i < nbits; i++) begin
      link_sck = 1'b1;
      word     = {word[30:0], link_miso};
      #60 link_sck = 1'b0;
      #100;
    end
    #100 link_sel_n = 1'b1;
    // gap of more than one link period before the next frame
    #400;
  endtask

  // unused vector packet bits carry no promise
  function automatic logic [31:0] unused_free(input logic [31:0] w);
    return w & 32'hffe73fff;
  endfunction

  // long address: first message word sits right after the vector word
  function automatic logic [6:0] first_msg_pos(input logic [6:0] vpos, input logic lng,
                                               input logic [6:0] st);
    return lng ? vpos + 7'h01 : st;
  endfunction
endmodule
`default_nettype wire

// File: dv/pvf_formatter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pvf_formatter_tb
  import pvf_pkg::*;
;

  // ****************************************************************
  // signals and instances
  // ****************************************************************
  localparam logic [2:0] NUM_T [3] = '{3'b011, 3'b100, 3'b111};
  localparam logic [2:0] OTH_T [3] = '{3'b000, 3'b101, 3'b110};
  logic              clk, reset, vec_valid, vec_check_fail, vec_value_bad, vec_long;
  logic              msg_valid, msg_error, reg_wr, reg_rd;
  logic [2:0]        vec_type, vec_bit_errors;
  logic [6:0]        vec_position, vec_length, vec_start, msg_position;
  logic [1:0]        vec_phase, msg_phase;
  logic [3:0]        vec_check_bits;
  logic [20:0]       msg_data;
  logic [REG_AW-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, rd, got;
  logic              link_sck, link_sel_n, link_miso, pkt_ready, all_frame, irq;
  logic              addr_valid, addr_tone_only;
  logic [6:0]        addr_position;
  int                fails, comparisons;

  pvf_formatter u_dut (
    .clk, .reset, .addr_valid, .addr_tone_only, .addr_position,
    .vec_valid, .vec_type, .vec_position, .vec_phase, .vec_bit_errors, .vec_check_fail,
    .vec_value_bad, .vec_long, .vec_check_bits, .vec_length, .vec_start, .msg_valid,
    .msg_position, .msg_phase, .msg_error, .msg_data, .link_sck, .link_sel_n, .link_miso,
    .pkt_ready, .all_frame, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq
  );

  pvf_host_model u_host (.link_miso, .link_sck, .link_sel_n);

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ****************************************************************
  // access tasks and checks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rd = reg_rdata;
    chk(what, exp, rd);
  endtask

  task automatic send_vec(input logic [2:0] t, input logic [6:0] pos, input logic [1:0] ph,
                          input logic [2:0] errs, input logic cf, input logic bad,
                          input logic lng, input logic [3:0] k, input logic [6:0] len,
                          input logic [6:0] st);
    @(posedge clk);
    vec_type       <= t;
    vec_position   <= pos;
    vec_phase      <= ph;
    vec_bit_errors <= errs;
    vec_check_fail <= cf;
    vec_value_bad  <= bad;
    vec_long       <= lng;
    vec_check_bits <= k;
    vec_length     <= len;
    vec_start      <= st;
    vec_valid      <= 1'b1;
    @(posedge clk);
    vec_valid      <= 1'b0;
  endtask

  task automatic send_addr(input logic tone, input logic [6:0] pos);
    @(posedge clk);
    addr_tone_only <= tone;
    addr_position  <= pos;
    addr_valid     <= 1'b1;
    @(posedge clk);
    addr_valid     <= 1'b0;
  endtask

  task automatic send_msg(input logic [6:0] pos, input logic [1:0] ph, input logic [20:0] d);
    @(posedge clk);
    msg_position <= pos;
    msg_phase    <= ph;
    msg_data     <= d;
    msg_valid    <= 1'b1;
    @(posedge clk);
    msg_valid    <= 1'b0;
  endtask

  // expected vector packet, byte 3 down to byte 0
  function automatic logic [31:0] vexp(input logic [2:0] t, input logic [6:0] pos,
                                       input logic e, input logic [1:0] ph,
                                       input logic [3:0] k, input logic [6:0] len,
                                       input logic [6:0] st);
    logic num;
    num         = (t == 3'b011) || (t == 3'b100) || (t == 3'b111);
    vexp[31:16] = {1'b0, pos, e, ph, 2'b00, t};
    vexp[15:0]  = num ? {2'b00, k, len[2:0], st} : {2'b00, len, st};
  endfunction

  // packet waits from the cycle after the request until the host reads it
  task automatic read_pkt(input logic [31:0] exp, input logic vec);
    #1 chk("pkt_ready", 32'h1, {31'h0, pkt_ready});
    u_host.read_packet(32, got);
    chk("packet", exp, vec ? u_host.unused_free(got) : got);
    chk("pkt_ready after read", 32'h0, {31'h0, pkt_ready});
  endtask

  task automatic vec_case(input logic [2:0] t, input logic [6:0] pos, input logic [1:0] ph,
                          input logic [2:0] errs, input logic cf, input logic bad,
                          input logic lng, input logic [3:0] k, input logic [6:0] len,
                          input logic [6:0] st, input logic e);
    send_vec(t, pos, ph, errs, cf, bad, lng, k, len, st);
    read_pkt(vexp(t, pos, e, ph, k, len, st), 1'b1);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // hang guard well above the longest run
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    {vec_valid, vec_check_fail, vec_value_bad, vec_long, msg_valid, msg_error} = 6'h0;
    {reg_wr, reg_rd, vec_type, vec_bit_errors, vec_phase, msg_phase} = 12'h0;
    {vec_position, vec_length, vec_start, msg_position} = 28'h0;
    {vec_check_bits, msg_data, reg_addr, reg_wdata} = 61'h0;
    {addr_valid, addr_tone_only, addr_position} = 9'h0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk("idle outputs", 32'h0, {29'h0, pkt_ready, all_frame, irq});
    reg_chk("ctrl reset", REG_CTRL, 32'h1);
    reg_chk("mask reset", REG_MASK, 32'h0);
    reg_chk("state reset", REG_STATE, 32'h0);
    reg_chk("unmapped", 4'h2, 32'h0);
    // numeric types, boundary positions, starts and lengths
    for (int i = 0; i < 3; i++)
      vec_case(NUM_T[i], 7'd2 + 7'(i * 40), 2'(i), 3'h0, 1'b0, 1'b0, 1'b0, 4'h9 ^ 4'(i),
               7'(i * 3 + 1), 7'd3 + 7'(i * 42), 1'b0);
    // other types enter all-frame mode; the host leaves it through ctrl
    for (int i = 0; i < 3; i++) begin
      vec_case(OTH_T[i], 7'd87 - 7'(i * 42), 2'(3 - i), 3'h0, 1'b0, 1'b0, 1'b0, 4'h0,
               7'd1 + 7'(i * 42), 7'd3 + 7'(i * 42), 1'b0);
      chk("all_frame on", 32'h1, {31'h0, all_frame});
      reg_write(REG_CTRL, 32'h3);
      #1 chk("all_frame off", 32'h0, {31'h0, all_frame});
    end
    // error flag causes, a bad start value first and too many bit errors last
    for (int i = 0; i < 5; i++)
      vec_case(3'b011, 7'd20, 2'd1, (i == 4) ? 3'h3 : ((i == 3) ? 3'h2 : 3'h0), i == 1,
               i == 2, 1'b0, 4'h5, 7'h0, (i == 0) ? 7'd2 : 7'd10, i != 3);
    // message of the errored vector is dropped
    reg_write(REG_STATUS, 32'hf);
    send_msg(7'd10, 2'd1, 21'h0a5a5);
    #1 chk("no message packet", 32'h0, {31'h0, pkt_ready});
    reg_chk("status drop", REG_STATUS, 32'h8);
    // long address: first message word follows the vector word
    vec_case(3'b011, 7'd30, 2'd2, 3'h0, 1'b0, 1'b0, 1'b1, 4'h3, 7'h1, 7'd40, 1'b0);
    send_msg(u_host.first_msg_pos(7'd30, 1'b1, 7'd40), 2'd2, 21'h1abcde);
    read_pkt({1'b0, 7'd31, 1'b0, 2'd2, 21'h1abcde}, 1'b0);
    // short frame leaves the packet in place
    send_vec(3'b100, 7'd50, 2'd3, 3'h0, 1'b0, 1'b0, 1'b0, 4'hc, 7'h2, 7'd60);
    #1 u_host.read_packet(16, got);
    chk("pkt kept", 32'h1, {31'h0, pkt_ready});
    read_pkt(vexp(3'b100, 7'd50, 1'b0, 2'd3, 4'hc, 7'h2, 7'd60), 1'b1);
    // address follow-up: missing, matching and misplaced vectors; short types
    reg_write(REG_STATUS, 32'hf);
    send_addr(1'b1, 7'd5);
    reg_chk("tone-only", REG_STATE, 32'h0);
    send_addr(1'b0, 7'd6);
    reg_chk("addr pending", REG_STATE, 32'h4);
    send_addr(1'b0, 7'd7);
    reg_chk("no vector", REG_STATUS, 32'h4);
    reg_write(REG_STATUS, 32'h4);
    send_vec(3'b001, 7'd7, 2'd0, 3'h0, 1'b0, 1'b0, 1'b0, 4'h0, 7'h1, 7'd3);
    #1 chk("short ins", 32'h1, {30'h0, pkt_ready, all_frame});
    reg_chk("matched", REG_STATUS, 32'h0);
    reg_write(REG_CTRL, 32'h3);
    send_addr(1'b0, 7'd8);
    send_vec(3'b010, 7'd9, 2'd0, 3'h0, 1'b0, 1'b0, 1'b0, 4'h0, 7'h1, 7'd3);
    #1 chk("short msg", 32'h0, {30'h0, pkt_ready, all_frame});
    reg_chk("misplaced", REG_STATUS, 32'h4);
    // overrun raises the masked interrupt; write one clears it
    reg_write(REG_STATUS, 32'hf);
    reg_write(REG_MASK, 32'h2);
    reg_chk("mask", REG_MASK, 32'h2);
    send_vec(3'b111, 7'd60, 2'd0, 3'h0, 1'b0, 1'b0, 1'b0, 4'h1, 7'h7, 7'd70);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    send_vec(3'b011, 7'd61, 2'd1, 3'h0, 1'b0, 1'b0, 1'b0, 4'h2, 7'h0, 7'd71);
    #1 chk("irq overrun", 32'h1, {31'h0, irq});
    reg_chk("status overrun", REG_STATUS, 32'h2);
    reg_write(REG_STATUS, 32'h2);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    read_pkt(vexp(3'b111, 7'd60, 1'b0, 2'd0, 4'h1, 7'h7, 7'd70), 1'b1);
    reg_chk("status sent", REG_STATUS, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
